/* File: include/mau_pkg.sv */
// Package for the master attribute and user bit logic
package mau_pkg;
    // Extra user bits above the configured user width
    localparam int EXTRA_USER_BITS  = 13;
    localparam int OC_BIT_OFS       = 12;
    localparam int CTX_LSB_OFS      = 8;
    localparam int S2_LSB_OFS       = 4;
    localparam int S1_LSB_OFS       = 0;
    localparam int HW_ATTR_W        = 4;
    localparam int DESC_HW_LSB      = 59;
    localparam int DESC_W           = 64;
    localparam int USER_W_DEFAULT   = 8;
    localparam int ADDR_W_DEFAULT   = 48;

    // Inner/outer cacheability encodings of the translated type
    localparam logic [1:0] CACHE_NC = 2'h0;
    localparam logic [1:0] CACHE_WT = 2'h1;
    localparam logic [1:0] CACHE_WB = 2'h2;

    // Master cache type field values
    localparam logic [3:0] AXCACHE_NC_BUF  = 4'h3;
    localparam logic [3:0] AXCACHE_WB_BASE = 4'hb;
    localparam logic [3:0] AXCACHE_RA_BIT  = 4'h4;
    localparam logic [3:0] AXCACHE_WA_BIT  = 4'h8;

    // Master domain encodings
    localparam logic [1:0] DOM_NON_SH   = 2'h0;
    localparam logic [1:0] DOM_INNER_SH = 2'h1;
    localparam logic [1:0] DOM_OUTER_SH = 2'h2;
    localparam logic [1:0] DOM_SYSTEM   = 2'h3;

    localparam logic [1:0] BURST_FIXED  = 2'h0;

    // Shareability of the translated type
    localparam logic [1:0] SH_NON   = 2'h0;
    localparam logic [1:0] SH_OUTER = 2'h2;
    localparam logic [1:0] SH_INNER = 2'h3;

    // Translated normal memory type
    typedef struct packed {
        logic [1:0] inner;
        logic [1:0] outer;
        logic       rd_alloc;
        logic       wr_alloc;
        logic [1:0] share;
    } mau_mem_type_t;

    // Converted master attributes
    typedef struct packed {
        logic [3:0] cache;
        logic [1:0] domain;
        logic       lock;
        logic       outer_cacheable;
    } mau_attr_t;
endpackage

/* File: hw/mau_hw_attr.sv */
`timescale 1ns/1ns
// Per-stage hardware attribute nibble from a final-level descriptor
module mau_hw_attr
#(
    parameter int ATTR_W = mau_pkg::HW_ATTR_W
)
(
    input  wire logic [mau_pkg::DESC_W-1:0] desc,
    input  wire logic [ATTR_W-1:0]          use_en,
    input  wire logic [ATTR_W-1:0]          block_en,
    output logic      [ATTR_W-1:0]          attr
);
    // Refuse a nibble that would run past the top of the descriptor
    initial
    begin
        if (ATTR_W < 1 || mau_pkg::DESC_HW_LSB + ATTR_W > mau_pkg::DESC_W)
        begin
            $error("mau_hw_attr: attribute width too large");
        end
    end

    // Bit n taken from descriptor bit n+59 when enabled and not blocked
    always_comb
    begin
        attr = desc[mau_pkg::DESC_HW_LSB +: ATTR_W] & use_en & ~block_en;
    end
endmodule

/* File: hw/mau_master_attr.sv */
`timescale 1ns/1ns
// Master port attribute conversion and extra user bit builder
//
// How it works
// - Non-WB normal: NC bufferable, system, lock passed
// - WB/WB: write-back alloc hints, lock 0, domain
// - Master user buses carry thirteen extra bits
// - Outer-cacheable flag on user bit w+12
// - Entry context bits on w+11 to w+8
// - Stage 2 on w+7:w+4, stage 1 w+3:w
// - Stage 1 bit only if stage 2 unused
// - Stage 2 bit from descriptor if permitted
// - Implementation fields written zero, ignored on read
// - Lock marks exclusive; walk port never locks
module mau_master_attr
#(
    parameter int USER_W = mau_pkg::USER_W_DEFAULT,
    parameter int ADDR_W = mau_pkg::ADDR_W_DEFAULT
)
(
    input  wire logic                                      mclk,
    input  wire logic                                      rst,
    input  wire logic                                      ax_valid,
    input  wire logic                                      ax_is_write,
    input  wire logic [ADDR_W-1:0]                         ax_addr,
    input  wire logic [1:0]                                ax_burst,
    input  wire logic                                      slave_lock,
    input  wire logic [USER_W-1:0]                         slave_user,
    input  wire mau_pkg::mau_mem_type_t                    mem_type,
    input  wire logic [mau_pkg::HW_ATTR_W-1:0]             context_attr_field,
    input  wire logic [mau_pkg::DESC_W-1:0]                s1_desc,
    input  wire logic [mau_pkg::DESC_W-1:0]                s2_desc,
    input  wire logic [mau_pkg::HW_ATTR_W-1:0]             s1_hw_use_en,
    input  wire logic [mau_pkg::HW_ATTR_W-1:0]             s2_hw_use_en,
    input  wire logic                                      ax_ready,
    output logic                                           arvalid_m,
    output logic                                           awvalid_m,
    output logic      [ADDR_W-1:0]                         addr_m,
    output logic      [3:0]                                cache_m,
    output logic      [1:0]                                domain_m,
    output logic                                           lock_m,
    output logic      [USER_W+mau_pkg::EXTRA_USER_BITS-1:0] aruser_m,
    output logic      [USER_W+mau_pkg::EXTRA_USER_BITS-1:0] awuser_m
);
    localparam int UW = USER_W + mau_pkg::EXTRA_USER_BITS;
    localparam int OC_POS  = USER_W + mau_pkg::OC_BIT_OFS;
    localparam int CTX_LSB = USER_W + mau_pkg::CTX_LSB_OFS;
    localparam int S2_LSB  = USER_W + mau_pkg::S2_LSB_OFS;
    localparam int S1_LSB  = USER_W + mau_pkg::S1_LSB_OFS;

    // Refuse widths the bit layout cannot serve
    initial
    begin
        if (USER_W < 1 || ADDR_W < 1)
        begin
            $error("mau_master_attr: bad width parameter");
        end
        if (mau_pkg::OC_BIT_OFS + 1 != mau_pkg::EXTRA_USER_BITS)
        begin
            $error("mau_master_attr: extra user field layout does not fit");
        end
    end

    // Per-stage nibbles, converted attributes and the stall flag
    logic [mau_pkg::HW_ATTR_W-1:0] stage1_hw_attr_field;
    logic [mau_pkg::HW_ATTR_W-1:0] stage2_hw_attr_field;
    mau_pkg::mau_attr_t            attr;
    logic [UW-1:0]                 user_full;
    logic                          busy;

    // Stage 2 nibble: gated only by its own permission
    mau_hw_attr #(
        .ATTR_W   (mau_pkg::HW_ATTR_W)
    ) u_s2 (
        .desc     (s2_desc),
        .use_en   (s2_hw_use_en),
        .block_en ('0),
        .attr     (stage2_hw_attr_field)
    );

    // Stage 1 nibble: blocked where stage 2 owns the bit
    mau_hw_attr #(
        .ATTR_W   (mau_pkg::HW_ATTR_W)
    ) u_s1 (
        .desc     (s1_desc),
        .use_en   (s1_hw_use_en),
        .block_en (s2_hw_use_en),
        .attr     (stage1_hw_attr_field)
    );

    // Cache, domain and lock conversion of the translated normal type
    always_comb
    begin
        attr.outer_cacheable = (mem_type.outer == mau_pkg::CACHE_WT) ||
                               (mem_type.outer == mau_pkg::CACHE_WB);
        if (mem_type.inner == mau_pkg::CACHE_WB && mem_type.outer == mau_pkg::CACHE_WB)
        begin
            attr.cache = mau_pkg::AXCACHE_WB_BASE
                       | (mem_type.rd_alloc ? mau_pkg::AXCACHE_RA_BIT : 4'h0)
                       | (mem_type.wr_alloc ? mau_pkg::AXCACHE_WA_BIT : 4'h0);
            attr.lock  = 1'b0;
            // A fixed WB/WB burst is never marked shareable; other types keep the system domain
            if (ax_burst == mau_pkg::BURST_FIXED)
            begin
                attr.domain = mau_pkg::DOM_NON_SH;
            end
            else if (mem_type.share == mau_pkg::SH_INNER)
            begin
                attr.domain = mau_pkg::DOM_INNER_SH;
            end
            else if (mem_type.share == mau_pkg::SH_OUTER)
            begin
                attr.domain = mau_pkg::DOM_OUTER_SH;
            end
            else
            begin
                attr.domain = mau_pkg::DOM_NON_SH;
            end
        end
        else
        begin
            attr.cache  = mau_pkg::AXCACHE_NC_BUF;
            attr.domain = mau_pkg::DOM_SYSTEM;
            attr.lock   = slave_lock;
        end
    end

    // Extra bits stacked above the slave user bits; nothing else is filled in
    always_comb
    begin
        user_full = '0;
        user_full[USER_W-1:0] = slave_user;
        user_full[S1_LSB +: mau_pkg::HW_ATTR_W]  = stage1_hw_attr_field;
        user_full[S2_LSB +: mau_pkg::HW_ATTR_W]  = stage2_hw_attr_field;
        user_full[CTX_LSB +: mau_pkg::HW_ATTR_W] = context_attr_field;
        user_full[OC_POS] = attr.outer_cacheable;
    end

    // Output stage: hold until the interconnect accepts
    logic              nxt_arvalid;
    logic              nxt_awvalid;
    logic [ADDR_W-1:0] nxt_addr;
    logic [3:0]        nxt_cache;
    logic [1:0]        nxt_domain;
    logic              nxt_lock;
    logic [UW-1:0]     nxt_aruser;
    logic [UW-1:0]     nxt_awuser;
    logic              arvalid_ff;
    logic              awvalid_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [3:0]        cache_ff;
    logic [1:0]        domain_ff;
    logic              lock_ff;
    logic [UW-1:0]     aruser_ff;
    logic [UW-1:0]     awuser_ff;

    assign busy = (arvalid_ff || awvalid_ff) && !ax_ready;

    // Load all fields in one cycle so they line up with valid
    always_comb
    begin
        nxt_arvalid = arvalid_ff;
        nxt_awvalid = awvalid_ff;
        nxt_addr    = addr_ff;
        nxt_cache   = cache_ff;
        nxt_domain  = domain_ff;
        nxt_lock    = lock_ff;
        nxt_aruser  = aruser_ff;
        nxt_awuser  = awuser_ff;
        // While a beat stalls new inputs are ignored, so the source must hold them
        if (!busy)
        begin
            nxt_arvalid = ax_valid && !ax_is_write;
            nxt_awvalid = ax_valid && ax_is_write;
            if (ax_valid)
            begin
                nxt_addr   = ax_addr;
                nxt_cache  = attr.cache;
                nxt_domain = attr.domain;
                nxt_lock   = attr.lock;
                nxt_aruser = ax_is_write ? '0 : user_full;
                nxt_awuser = ax_is_write ? user_full : '0;
            end
        end
    end

    // Register stage; a synchronous reset clears every output
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            arvalid_ff <= 1'b0;
            awvalid_ff <= 1'b0;
            addr_ff    <= '0;
            cache_ff   <= 4'h0;
            domain_ff  <= 2'h0;
            lock_ff    <= 1'b0;
            aruser_ff  <= '0;
            awuser_ff  <= '0;
        end
        else
        begin
            arvalid_ff <= nxt_arvalid;
            awvalid_ff <= nxt_awvalid;
            addr_ff    <= nxt_addr;
            cache_ff   <= nxt_cache;
            domain_ff  <= nxt_domain;
            lock_ff    <= nxt_lock;
            aruser_ff  <= nxt_aruser;
            awuser_ff  <= nxt_awuser;
        end
    end

    // Every output comes straight from its flip-flop
    assign arvalid_m = arvalid_ff;
    assign awvalid_m = awvalid_ff;
    assign addr_m    = addr_ff;
    assign cache_m   = cache_ff;
    assign domain_m  = domain_ff;
    assign lock_m    = lock_ff;
    assign aruser_m  = aruser_ff;
    assign awuser_m  = awuser_ff;
endmodule

/* File: bench/mau_ic_model.sv */
`timescale 1ns/1ns
// Interconnect model that accepts master beats promptly or every other cycle
module mau_ic_model
#(
    parameter int USER_W = 8
)
(
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               slow,
    input  wire logic [USER_W+12:0] user,
    output logic                    ax_ready,
    output logic      [3:0]         hw_attr
);
    // Slow mode stalls every other cycle so that held beats get exercised
    always_ff @(posedge mclk)
    begin
        ax_ready <= rst || !slow || !ax_ready;
    end
    // Receiver merges the two stages by OR, so stage 2 wins where it is enabled
    assign hw_attr = user[USER_W+7:USER_W+4] | user[USER_W+3:USER_W];
endmodule

/* File: bench/mau_master_attr_checker.sv */
`timescale 1ns/1ns
// Assertion checker for the master attribute block
module mau_master_attr_checker
#(
    parameter int USER_W = 8
)
(
    input wire logic                   mclk,
    input wire logic                   rst,
    input wire logic                   ax_valid,
    input wire logic                   ax_is_write,
    input wire logic [1:0]             ax_burst,
    input wire logic                   slave_lock,
    input wire mau_pkg::mau_mem_type_t mem_type,
    input wire logic [3:0]             context_attr_field,
    input wire logic [63:0]            s1_desc,
    input wire logic [63:0]            s2_desc,
    input wire logic [3:0]             s1_hw_use_en,
    input wire logic [3:0]             s2_hw_use_en,
    input wire logic                   ax_ready,
    input wire logic                   arvalid_m,
    input wire logic                   awvalid_m,
    input wire logic [3:0]             cache_m,
    input wire logic [1:0]             domain_m,
    input wire logic                   lock_m,
    input wire logic [USER_W+12:0]     aruser_m,
    input wire logic [USER_W+12:0]     awuser_m
);
    logic               tk;
    logic               wbwb;
    logic [USER_W+12:0] uo;
    // A beat is taken unless a held beat is stalled; the idle user bus is zero
    assign tk = ax_valid && !((arvalid_m || awvalid_m) && !ax_ready);
    assign wbwb = mem_type.inner == 2'h2 && mem_type.outer == 2'h2;
    assign uo = aruser_m | awuser_m;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    valid_dir_a: assert property (tk |=>
        awvalid_m == $past(ax_is_write) && arvalid_m != awvalid_m)
        else $error("valid direction wrong");
    nc_attr_a: assert property (tk && !wbwb |=>
        cache_m == 4'h3 && domain_m == 2'h3 && lock_m == $past(slave_lock))
        else $error("non write-back attributes wrong");
    wb_attr_a: assert property (tk && wbwb |=>
        cache_m[1:0] == 2'h3 && !lock_m && cache_m[2] == $past(mem_type.rd_alloc))
        else $error("write-back attributes wrong");
    fixed_dom_a: assert property (tk && wbwb && ax_burst == 2'h0 |=>
        domain_m == 2'h0)
        else $error("fixed burst domain wrong");
    oc_bit_a: assert property (tk |=>
        uo[USER_W+12] == ($past(mem_type.outer) != 2'h0))
        else $error("outer cacheable bit wrong");
    ctx_bits_a: assert property (tk |=>
        uo[USER_W+11:USER_W+8] == $past(context_attr_field))
        else $error("context bits wrong");
    s2_bits_a: assert property (tk |=>
        uo[USER_W+7:USER_W+4] == ($past(s2_desc[62:59]) & $past(s2_hw_use_en)))
        else $error("stage 2 nibble wrong");
    s1_bits_a: assert property (tk |=>
        uo[USER_W+3:USER_W] == ($past(s1_desc[62:59]) & $past(s1_hw_use_en)
        & ~$past(s2_hw_use_en)))
        else $error("stage 1 nibble wrong");
    hold_beat_a: assert property ((arvalid_m || awvalid_m) && !ax_ready |=>
        $stable(cache_m) && $stable(uo) && $stable(lock_m) && $stable(domain_m))
        else $error("held beat changed");
endmodule
bind mau_master_attr mau_master_attr_checker #(.USER_W(USER_W))
    mau_master_attr_checker_inst (.mclk, .rst, .ax_valid, .ax_is_write, .ax_burst, .slave_lock,
    .mem_type, .context_attr_field, .s1_desc, .s2_desc, .s1_hw_use_en, .s2_hw_use_en, .ax_ready,
    .arvalid_m, .awvalid_m, .cache_m, .domain_m, .lock_m, .aruser_m, .awuser_m);

/* File: bench/mau_master_attr_tb_top.sv */
`timescale 1ns/1ns
// Self-checking testbench for the master attribute block
module mau_master_attr_tb_top;
    localparam int UW = 8;
    localparam logic [63:0] S1D = 64'h2800_0000_0000_0000;
    localparam logic [63:0] S2D = 64'h5000_0000_0000_0000;
    localparam logic [1:0] SHR [3] = '{2'h0, 2'h2, 2'h3};
    logic                   mclk;
    logic                   rst;
    logic                   ax_valid;
    logic                   ax_is_write;
    logic [47:0]            ax_addr;
    logic [1:0]             ax_burst;
    logic                   slave_lock;
    logic [UW-1:0]          slave_user;
    mau_pkg::mau_mem_type_t mem_type;
    logic [3:0]             ctx;
    logic [3:0]             s1_en;
    logic [3:0]             s2_en;
    logic [63:0]            s1_desc;
    logic [63:0]            s2_desc;
    logic                   ax_ready;
    logic                   slow;
    logic                   arvalid_m;
    logic                   awvalid_m;
    logic [47:0]            addr_m;
    logic [3:0]             cache_m;
    logic [1:0]             domain_m;
    logic                   lock_m;
    logic [UW+12:0]         aruser_m;
    logic [UW+12:0]         awuser_m;
    logic [3:0]             hw_attr;
    int                     error_cnt;
    int                     tests_run;
    mau_master_attr mau_master_attr_inst (.mclk, .rst, .ax_valid, .ax_is_write, .ax_addr,
        .ax_burst, .slave_lock, .slave_user, .mem_type, .context_attr_field(ctx), .s1_desc,
        .s2_desc, .s1_hw_use_en(s1_en), .s2_hw_use_en(s2_en), .ax_ready, .arvalid_m, .awvalid_m,
        .addr_m, .cache_m, .domain_m, .lock_m, .aruser_m, .awuser_m);
    mau_ic_model #(.USER_W(UW)) mau_ic_model_inst (.mclk, .rst, .slow, .user(awuser_m | aruser_m),
        .ax_ready, .hw_attr);
    // 20 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // One request built from k, held until taken, then its beat is checked
    task automatic xfer(input int k);
        logic           wb;
        logic           stall;
        logic [3:0]     s1;
        logic [3:0]     s2;
        logic [3:0]     cache;
        logic [1:0]     dom;
        logic [UW+12:0] eu;
        @(posedge mclk);
        ax_valid <= 1'b1;
        ax_is_write <= k[0];
        ax_addr <= 48'(k);
        ax_burst <= (k / 18 == 1) ? mau_pkg::BURST_FIXED : 2'h1;
        slave_lock <= k[1];
        slave_user <= UW'(k * 7);
        mem_type <= '{2'(k % 3), 2'((k / 3) % 3), k[2], k[3], SHR[(k / 9) % 3]};
        ctx <= k[3:0];
        s1_en <= k[3:0];
        s2_en <= k[5:2];
        s1_desc <= k[4] ? ~S1D : S1D;
        s2_desc <= k[5] ? ~S2D : S2D;
        slow <= k >= 27;
        do
        begin
            @(negedge mclk);
            stall = (arvalid_m || awvalid_m) && !ax_ready;
            @(posedge mclk);
        end
        while (stall);
        ax_valid <= 1'b0;
        @(negedge mclk);
        wb = k % 9 == 8;
        s2 = s2_desc[62:59] & s2_en;
        s1 = s1_desc[62:59] & s1_en & ~s2_en;
        dom = !wb ? mau_pkg::DOM_SYSTEM
            : ax_burst == mau_pkg::BURST_FIXED ? mau_pkg::DOM_NON_SH
            : mem_type.share == mau_pkg::SH_INNER ? mau_pkg::DOM_INNER_SH
            : mem_type.share == mau_pkg::SH_OUTER ? mau_pkg::DOM_OUTER_SH : mau_pkg::DOM_NON_SH;
        cache = !wb ? mau_pkg::AXCACHE_NC_BUF : mau_pkg::AXCACHE_WB_BASE
              | ({4{mem_type.rd_alloc}} & mau_pkg::AXCACHE_RA_BIT)
              | ({4{mem_type.wr_alloc}} & mau_pkg::AXCACHE_WA_BIT);
        eu = {mem_type.outer != mau_pkg::CACHE_NC, ctx, s2, s1, slave_user};
        chk({cache_m, domain_m, lock_m}, {cache, dom, wb ? 1'b0 : slave_lock});
        chk({arvalid_m, awvalid_m, addr_m}, {!ax_is_write, ax_is_write, ax_addr});
        chk(awuser_m, ax_is_write ? eu : '0);
        chk(aruser_m, ax_is_write ? '0 : eu);
        chk(hw_attr, s1 | s2);
    endtask
    // Main sequence: reset, all type combinations with prompt then slow acceptance
    initial
    begin
        error_cnt = 0;
        tests_run = 0;
        rst = 1'b1;
        ax_valid = 1'b0;
        ax_is_write = 1'b0;
        ax_addr = '0;
        ax_burst = 2'h1;
        slave_lock = 1'b0;
        slave_user = '0;
        mem_type = '0;
        ctx = 4'h0;
        s1_en = 4'h0;
        s2_en = 4'h0;
        s1_desc = S1D;
        s2_desc = S2D;
        slow = 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk({arvalid_m, awvalid_m, cache_m, lock_m, awuser_m, aruser_m}, '0);
        chk($bits(mau_master_attr_inst.awuser_m), UW + 13);
        chk($bits(mau_master_attr_inst.aruser_m), UW + 13);
        @(posedge mclk);
        rst <= 1'b0;
        for (int k = 0; k < 54; k++)
            xfer(k);
        $display("test attribute conversion done");
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk({arvalid_m, awvalid_m}, '0);
        $display("test idle drop done");
        test_done();
    end
    // Watchdog: the run needs a few hundred cycles at most
    initial
    begin
        repeat (3000) @(posedge mclk);
        error_cnt++;
        test_done();
    end
endmodule
